/* File: hdl/ldcb_pkg.sv */
// constants of the per-unit configuration register bank
// assumes a host front end that turns index/data port cycles into strobes
package ldcb_pkg;
    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_UNIT_SEL = 8'h07;
    localparam logic [7:0] IDX_ACT = 8'h30;
    localparam logic [7:0] IDX_BASE_H = 8'h60;
    localparam logic [7:0] IDX_BASE_L = 8'h61;
    localparam logic [7:0] IDX_BASE2_H = 8'h62;
    localparam logic [7:0] IDX_BASE2_L = 8'h63;
    localparam logic [7:0] IDX_IRQ1 = 8'h70;
    localparam logic [7:0] IDX_IRQ2 = 8'h72;
    localparam logic [7:0] IDX_DMA = 8'h74;
    localparam logic [7:0] IDX_RSV_LO = 8'h31;
    localparam logic [7:0] IDX_RSV_HI = 8'h5F;
    // ------------------------------------------------------------
    // unit numbers and bank slots
    // ------------------------------------------------------------
    localparam int N_BANK = 9;
    localparam logic [7:0] UNIT_FLOPPY = 8'h00;
    localparam logic [7:0] UNIT_PARALLEL = 8'h03;
    localparam logic [7:0] UNIT_SERIAL1 = 8'h04;
    localparam logic [7:0] UNIT_SERIAL2 = 8'h05;
    localparam logic [7:0] UNIT_KBD = 8'h07;
    localparam logic [7:0] UNIT_GAME = 8'h09;
    localparam logic [7:0] UNIT_WAKE = 8'h0A;
    localparam logic [7:0] UNIT_MIDI = 8'h0B;
    localparam logic [7:0] UNIT_HUB = 8'h0C;
    localparam logic [3:0] BANK_NONE = 4'h9;
    localparam logic [3:0] BANK_FLOPPY = 4'h0;
    localparam logic [3:0] BANK_PARALLEL = 4'h1;
    localparam logic [3:0] BANK_SERIAL2 = 4'h3;
    // ------------------------------------------------------------
    // reset values and implemented-register masks (bit = bank slot)
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_IRQ1_FLOPPY = 8'h06;
    localparam logic [7:0] RST_DMA_FLOPPY = 8'h02;
    localparam logic [7:0] RST_DMA_PAR = 8'h04;
    localparam logic [8:0] HAS_BASE1 = 9'h1EF;
    localparam logic [8:0] HAS_BASE2 = 9'h080;
    localparam logic [8:0] HAS_IRQ2 = 9'h010;
    localparam logic [8:0] HAS_DMA = 9'h003;
    // ------------------------------------------------------------
    // permitted base range per bank slot
    // ------------------------------------------------------------
    localparam logic [15:0] BASE_MIN [N_BANK] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0000,
                                                  16'h0100, 16'h0000, 16'h0100, 16'h0100};
    localparam logic [15:0] BASE_MAX [N_BANK] = '{16'h0FF8, 16'h0FFC, 16'h0FF8, 16'h0FF8, 16'hFFFF,
                                                  16'h0FFF, 16'h0F7F, 16'h0FFE, 16'h0FFE};
    localparam logic [15:0] BASE_ALIGN [N_BANK] = '{16'h0007, 16'h0003, 16'h0007, 16'h0007, 16'h0000,
                                                    16'h0000, 16'h007F, 16'h0001, 16'h0001};
endpackage

/* File: hdl/ldcb_bank.sv */
// banked per-unit configuration registers behind an index/data port pair
// assumes strobes come from logic on clk_i; soft and hard resets are
// one-cycle pulses on the same clock
`timescale 1ns/1ps

// How it works
// RL1: nine register banks; unit selector at index 0x07 picks which one is seen.
// RL2: host writes an index, then reads or writes via the data port.
// RL3: bank registers reachable only while in configuration state.
// RL4: index 0x30 bit 0 activates selected unit; bits 7..1 reserved.
// RL5: activate and base registers clear on every reset kind.
// RL6: indices 0x31 to 0x5F ignore writes and read zero.
// RL7: primary base: 0x60 holds bits 15..8, 0x61 bits 7..0.
// RL8: second base from 0x62 high byte and 0x63 low byte.
// RL9: base registers a unit does not use ignore writes, read zero.
// RL10: 0x70 in every bank; 0x72 only for keyboard, else reads zero.
// RL11: interrupts default to edge-triggered, active-high.
// RL12: 0x71, 0x73, 0x76 to 0xDF ignore writes and read zero.
// RL13: 0x74 only for floppy and parallel; 0x75 reads zero.
// RL14: 0xE0 to 0xFE vendor-defined, 0xFF reserved; here read zero.
// RL15: activate and power control bit linked; unit on when set.
// RL16: base outside permitted range disables the unit's decode.
// RL17: primary interrupt select resets to 0x06 for floppy, else 0x00.
// RL18: DMA select resets to 0x02 for floppy, 0x04 for units 3 and 5.
// RL19: data accesses steer to the bank selected at access time.
// RL20: activate bits 7..1 always read zero.
module ldcb_bank
    import ldcb_pkg::*;
(
    // clock and resets
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic soft_reset_i,
    input wire logic hard_reset_i,
    // configuration state and port strobes
    input wire logic cfg_mode_i,
    input wire logic index_wr_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic [7:0] wdata_i,
    // read answer
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // power control link, one bit per bank slot
    input wire logic [N_BANK-1:0] pwr_set_i,
    input wire logic [N_BANK-1:0] pwr_clr_i,
    // unit status
    output logic [N_BANK-1:0] unit_on_o,
    output logic [N_BANK-1:0] unit_decode_en_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // map a unit number onto a bank slot
    function automatic logic [3:0] bank_of(input logic [7:0] unit);
        case (unit)
            UNIT_FLOPPY: bank_of = 4'h0;
            UNIT_PARALLEL: bank_of = 4'h1;
            UNIT_SERIAL1: bank_of = 4'h2;
            UNIT_SERIAL2: bank_of = 4'h3;
            UNIT_KBD: bank_of = 4'h4;
            UNIT_GAME: bank_of = 4'h5;
            UNIT_WAKE: bank_of = 4'h6;
            UNIT_MIDI: bank_of = 4'h7;
            UNIT_HUB: bank_of = 4'h8;
            default: bank_of = BANK_NONE;
        endcase
    endfunction

    // reset value of the primary interrupt select
    function automatic logic [7:0] irq1_rst(input int b);
        irq1_rst = (b == int'(BANK_FLOPPY)) ? RST_IRQ1_FLOPPY : RST_ZERO;
    endfunction

    // reset value of the dma channel select
    function automatic logic [7:0] dma_rst(input int b);
        if (b == int'(BANK_FLOPPY)) begin
            dma_rst = RST_DMA_FLOPPY;
        end else if (b == int'(BANK_PARALLEL) || b == int'(BANK_SERIAL2)) begin
            dma_rst = RST_DMA_PAR;
        end else begin
            dma_rst = RST_ZERO;
        end
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] index;
    logic [7:0] unit_sel;
    logic act [N_BANK];
    logic [7:0] bah [N_BANK];
    logic [7:0] bal [N_BANK];
    logic [7:0] b2h [N_BANK];
    logic [7:0] b2l [N_BANK];
    logic [7:0] irq1 [N_BANK];
    logic [7:0] irq2 [N_BANK];
    logic [7:0] dma [N_BANK];

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // either of the two sync reset sources, soft or hard, clears the bank
    wire sync_clr = soft_reset_i || hard_reset_i;
    // RL3: configuration gate
    wire cfg_wr = cfg_mode_i && data_wr_i;
    wire cfg_rd = cfg_mode_i && data_rd_i;
    // RL19: bank chosen from the selector at access time
    wire [3:0] sel_bank = bank_of(unit_sel);
    wire sel_ok = (sel_bank != BANK_NONE);
    wire [3:0] rb = sel_ok ? sel_bank : 4'h0;
    wire [8:0] sel_bit = sel_ok ? (9'h001 << sel_bank) : 9'h000;
    // RL9 RL10 RL13: only implemented registers take writes or read back
    wire has_b1 = |(sel_bit & HAS_BASE1);
    wire has_b2 = |(sel_bit & HAS_BASE2);
    wire has_i2 = |(sel_bit & HAS_IRQ2);
    wire has_dm = |(sel_bit & HAS_DMA);

    // read selection; every unlisted index reads zero
    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        if (index == IDX_UNIT_SEL) begin
            rd_val = unit_sel;
        end else if (sel_ok) begin
            // RL6 RL12 RL14: reserved and vendor indices fall to zero
            case (index)
                // RL20: reserved activate bits read zero
                IDX_ACT: rd_val = {7'h00, act[rb]};
                // RL7: primary base bytes
                IDX_BASE_H: rd_val = has_b1 ? bah[rb] : 8'h00;
                IDX_BASE_L: rd_val = has_b1 ? bal[rb] : 8'h00;
                // RL8: second base bytes
                IDX_BASE2_H: rd_val = has_b2 ? b2h[rb] : 8'h00;
                IDX_BASE2_L: rd_val = has_b2 ? b2l[rb] : 8'h00;
                IDX_IRQ1: rd_val = irq1[rb];
                IDX_IRQ2: rd_val = has_i2 ? irq2[rb] : 8'h00;
                IDX_DMA: rd_val = has_dm ? dma[rb] : 8'h00;
                default: rd_val = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // index and selector
    // ------------------------------------------------------------
    // RL2: index port write latches the register index
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            index <= 8'h00;
        end else if (cfg_mode_i && index_wr_i) begin
            index <= wdata_i;
        end
    end

    // RL1: unit selector at index 0x07
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unit_sel <= 8'h00;
        end else if (sync_clr) begin
            unit_sel <= 8'h00;
        end else if (cfg_wr && index == IDX_UNIT_SEL) begin
            unit_sel <= wdata_i;
        end
    end

    // RL2: read answer one cycle after the strobe; zero outside config
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= cfg_rd ? rd_val : 8'h00;
            rvalid_o <= data_rd_i;
        end
    end

    // ------------------------------------------------------------
    // per-bank registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_BANK; g++) begin : g_bank
            wire we = cfg_wr && sel_bit[g];
            wire [15:0] base = {bah[g], bal[g]};

            // RL1 RL5 RL15: activate bit shared with the power control bit
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    act[g] <= 1'b0;
                end else if (sync_clr) begin
                    act[g] <= 1'b0;
                end else if (pwr_set_i[g]) begin
                    act[g] <= 1'b1;
                end else if (pwr_clr_i[g]) begin
                    act[g] <= 1'b0;
                end else if (we && index == IDX_ACT) begin
                    // RL4: only bit 0 is stored
                    act[g] <= wdata_i[0];
                end
            end

            // RL5 RL7 RL8 RL9: base address bytes
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    bah[g] <= RST_ZERO;
                    bal[g] <= RST_ZERO;
                    b2h[g] <= RST_ZERO;
                    b2l[g] <= RST_ZERO;
                end else if (sync_clr) begin
                    bah[g] <= RST_ZERO;
                    bal[g] <= RST_ZERO;
                    b2h[g] <= RST_ZERO;
                    b2l[g] <= RST_ZERO;
                end else if (we) begin
                    if (HAS_BASE1[g] && index == IDX_BASE_H) bah[g] <= wdata_i;
                    if (HAS_BASE1[g] && index == IDX_BASE_L) bal[g] <= wdata_i;
                    if (HAS_BASE2[g] && index == IDX_BASE2_H) b2h[g] <= wdata_i;
                    if (HAS_BASE2[g] && index == IDX_BASE2_L) b2l[g] <= wdata_i;
                end
            end

            // RL10 RL11 RL13 RL17 RL18: interrupt and dma selects
            // reset values leave the type bits clear: edge, active high
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    irq1[g] <= irq1_rst(g);
                    irq2[g] <= RST_ZERO;
                    dma[g] <= dma_rst(g);
                end else if (sync_clr) begin
                    irq1[g] <= irq1_rst(g);
                    irq2[g] <= RST_ZERO;
                    dma[g] <= dma_rst(g);
                end else if (we) begin
                    if (index == IDX_IRQ1) irq1[g] <= wdata_i;
                    if (HAS_IRQ2[g] && index == IDX_IRQ2) irq2[g] <= wdata_i;
                    if (HAS_DMA[g] && index == IDX_DMA) dma[g] <= wdata_i;
                end
            end

            // RL15 RL16: unit on, decode only when base in permitted range
            wire in_range = (base >= BASE_MIN[g]) && (base <= BASE_MAX[g]) &&
                            ((base & BASE_ALIGN[g]) == 16'h0000);
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    unit_on_o[g] <= 1'b0;
                    unit_decode_en_o[g] <= 1'b0;
                end else begin
                    unit_on_o[g] <= act[g];
                    unit_decode_en_o[g] <= act[g] && in_range;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_cfg_gate_read: assert property ( // RL3
        !cfg_mode_i && data_rd_i |=> rvalid_o && rdata_o == 8'h00)
        else $error("read outside configuration state returned data");
    a_reserved_low_zero: assert property ( // RL6
        cfg_rd && index >= IDX_RSV_LO && index <= IDX_RSV_HI |=> rdata_o == 8'h00)
        else $error("reserved index 0x31-0x5F read non-zero");
    a_act_upper_zero: assert property ( // RL20
        cfg_rd && index == IDX_ACT |=> rdata_o[7:1] == 7'h00)
        else $error("activate reserved bits read non-zero");
    a_act_write_takes: assert property ( // RL4
        cfg_wr && sel_ok && index == IDX_ACT && !sync_clr && pwr_set_i == '0 && pwr_clr_i == '0
        |=> act[rb] == $past(wdata_i[0]) ##1 unit_on_o[rb] == $past(wdata_i[0], 2))
        else $error("activate write not reflected");
    a_reset_clears_act: assert property ( // RL5
        sync_clr |=> !act[0] && bah[0] == 8'h00 ##1 !unit_on_o[0])
        else $error("reset did not clear activate and base");
    a_floppy_irq_default: assert property ( // RL17
        sync_clr |=> irq1[0] == RST_IRQ1_FLOPPY && irq1[1] == RST_ZERO)
        else $error("interrupt select reset value wrong");
    a_dma_default: assert property ( // RL18
        sync_clr |=> dma[0] == RST_DMA_FLOPPY && dma[1] == RST_DMA_PAR)
        else $error("dma select reset value wrong");
    a_second_base_gate: assert property ( // RL9
        cfg_rd && index == IDX_BASE2_H && !has_b2 |=> rdata_o == 8'h00)
        else $error("unused second base read non-zero");
    a_dma_unused_zero: assert property ( // RL13
        cfg_rd && (index == IDX_DMA + 8'h01 || (index == IDX_DMA && !has_dm)) |=> rdata_o == 8'h00)
        else $error("unimplemented dma index read non-zero");
    a_power_link: assert property ( // RL15
        pwr_set_i[0] && !sync_clr |=> act[0] ##1 unit_on_o[0])
        else $error("power control set did not activate unit");
    a_decode_needs_on: assert property ( // RL16
        unit_decode_en_o[0] |-> unit_on_o[0])
        else $error("decode enabled on inactive unit");
    a_cfg_gate_write: assert property ( // RL3
        !cfg_mode_i && !sync_clr |=> $stable(index) && $stable(unit_sel))
        else $error("write outside configuration state changed index or selector");
    a_irq2_unused_zero: assert property ( // RL10
        cfg_rd && index == IDX_IRQ2 && !has_i2 |=> rdata_o == 8'h00)
        else $error("unused secondary interrupt select read non-zero");
    a_decode_floor: assert property ( // RL16
        unit_decode_en_o[0] |-> $past(bah[0]) != 8'h00)
        else $error("floppy decode enabled with base below permitted range");
endmodule // ldcb_bank

/* File: sim/ldcb_host.sv */
// host model that drives the index and data ports of the bank
// assumes the bench calls its tasks; strobes move 1 ns after clk_i rises
`timescale 1ns/1ps
module ldcb_host (
    // clock
    input wire logic clk_i,
    // port strobes toward the bank
    output logic index_wr_o,
    output logic data_wr_o,
    output logic data_rd_o,
    output logic [7:0] wdata_o,
    // read answer from the bank
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    // ------------------------------------------------------------
    // idle ports and port cycles
    // ------------------------------------------------------------
    // idle: strobes low, data bus not left at a stale value
    initial begin
        index_wr_o = 1'b0;
        data_wr_o = 1'b0;
        data_rd_o = 1'b0;
        wdata_o = 8'hA5;
    end
    task automatic port_wr(input logic is_idx, input logic [7:0] val);
        @(posedge clk_i);
        #1;
        index_wr_o = is_idx;
        data_wr_o = ~is_idx;
        wdata_o = val;
        @(posedge clk_i);
        #1;
        index_wr_o = 1'b0;
        data_wr_o = 1'b0;
        wdata_o = ~val; // released bus shows the inverse
    endtask
    task automatic get_data(output logic [7:0] d, output logic v);
        @(posedge clk_i);
        #1;
        data_rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        data_rd_o = 1'b0;
        d = rdata_i; // answer stands for this one cycle
        v = rvalid_i;
    endtask
endmodule // ldcb_host

/* File: sim/test_logical_device_config_bank.sv */
// self-checking bench of the per-unit configuration bank
// assumes ldcb_host as the host; clk_i 125 MHz, inputs move 1 ns after the edge
`timescale 1ns/1ps
module test_logical_device_config_bank;
    import ldcb_pkg::*;
    typedef struct packed {logic [7:0] unit; logic [7:0] idx; logic [7:0] wval; logic [7:0] rst; logic [7:0] want;} ldcb_row_s;
    localparam int N_ROW = 24;
    // unit, index, written, value after reset, value after write
    localparam ldcb_row_s ROWS [N_ROW] = '{
        '{8'h00, 8'h30, 8'hFF, 8'h00, 8'h01}, '{8'h00, 8'h60, 8'h03, 8'h00, 8'h03},
        '{8'h00, 8'h61, 8'hF8, 8'h00, 8'hF8}, '{8'h00, 8'h70, 8'h05, 8'h06, 8'h05},
        '{8'h00, 8'h74, 8'h03, 8'h02, 8'h03}, '{8'h00, 8'h62, 8'h55, 8'h00, 8'h00},
        '{8'h00, 8'h72, 8'h55, 8'h00, 8'h00}, '{8'h00, 8'h31, 8'hFF, 8'h00, 8'h00},
        '{8'h00, 8'h5F, 8'hFF, 8'h00, 8'h00}, '{8'h00, 8'h71, 8'hFF, 8'h00, 8'h00},
        '{8'h00, 8'h73, 8'hFF, 8'h00, 8'h00}, '{8'h00, 8'h75, 8'hFF, 8'h00, 8'h00},
        '{8'h00, 8'h76, 8'hFF, 8'h00, 8'h00}, '{8'h00, 8'hDF, 8'hFF, 8'h00, 8'h00},
        '{8'h00, 8'hE0, 8'hFF, 8'h00, 8'h00}, '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00},
        '{8'h03, 8'h74, 8'h01, 8'h04, 8'h01}, '{8'h04, 8'h60, 8'h0A, 8'h00, 8'h0A},
        '{8'h07, 8'h72, 8'h0C, 8'h00, 8'h0C}, '{8'h07, 8'h60, 8'h12, 8'h00, 8'h00},
        '{8'h0B, 8'h62, 8'h12, 8'h00, 8'h12}, '{8'h0B, 8'h63, 8'h34, 8'h00, 8'h34},
        '{8'h09, 8'h70, 8'h0F, 8'h00, 8'h0F}, '{8'h01, 8'h30, 8'h01, 8'h00, 8'h00}};
    logic clk_i;
    logic resetn_i;
    logic soft_reset_i;
    logic hard_reset_i;
    logic cfg_mode_i;
    logic index_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
    logic [7:0] rdata_o;
    logic rvalid_o;
    logic [N_BANK-1:0] pwr_set_i;
    logic [N_BANK-1:0] pwr_clr_i;
    logic [N_BANK-1:0] unit_on_o;
    logic [N_BANK-1:0] unit_decode_en_o;
    int errors;
    int total_checks;
    logic [7:0] d;
    // ------------------------------------------------------------
    // design, host model, clock
    // ------------------------------------------------------------
    ldcb_bank DUT (.clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i), .hard_reset_i(hard_reset_i),
        .cfg_mode_i(cfg_mode_i), .index_wr_i(index_wr), .data_wr_i(data_wr), .data_rd_i(data_rd),
        .wdata_i(wdata), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .pwr_set_i(pwr_set_i),
        .pwr_clr_i(pwr_clr_i), .unit_on_o(unit_on_o), .unit_decode_en_o(unit_decode_en_o));
    ldcb_host host (.clk_i(clk_i), .index_wr_o(index_wr), .data_wr_o(data_wr), .data_rd_o(data_rd),
        .wdata_o(wdata), .rdata_i(rdata_o), .rvalid_i(rvalid_o));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        host.port_wr(1'b1, idx);
        host.port_wr(1'b0, val);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] val);
        logic v;
        host.port_wr(1'b1, idx);
        host.get_data(val, v);
        chk({7'h00, v}, 8'h01);
    endtask
    // one-cycle pulse on a sync reset or a power control bit
    task automatic pulse(input int kind);
        @(posedge clk_i);
        #1;
        if (kind == 0) soft_reset_i = 1'b1;
        else if (kind == 1) hard_reset_i = 1'b1;
        else if (kind == 2) pwr_clr_i[0] = 1'b1;
        else pwr_set_i[0] = 1'b1;
        @(posedge clk_i);
        #1;
        soft_reset_i = 1'b0;
        hard_reset_i = 1'b0;
        pwr_clr_i = '0;
        pwr_set_i = '0;
        @(posedge clk_i);
        #1;
    endtask
    // watchdog cuts a hang short
    initial begin
        #60000;
        errors++;
        complete_run();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        resetn_i = 1'b0;
        soft_reset_i = 1'b0;
        hard_reset_i = 1'b0;
        cfg_mode_i = 1'b1;
        pwr_set_i = '0;
        pwr_clr_i = '0;
        repeat (4) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        @(posedge clk_i);
        #1;
        chk({7'h00, rvalid_o}, 8'h00);
        chk(unit_on_o[7:0], 8'h00);
        // table rows: reset value, write, read back
        for (int i = 0; i < N_ROW; i++) begin
            wr(IDX_UNIT_SEL, ROWS[i].unit);
            rd(ROWS[i].idx, d);
            chk(d, ROWS[i].rst);
            host.port_wr(1'b0, ROWS[i].wval);
            rd(ROWS[i].idx, d);
            chk(d, ROWS[i].want);
        end
        // bank switch back keeps floppy values; decode follows base range
        wr(IDX_UNIT_SEL, 8'h00);
        rd(8'h60, d);
        chk(d, 8'h03);
        chk({7'h00, unit_on_o[0]}, 8'h01);
        chk({7'h00, unit_decode_en_o[0]}, 8'h01);
        wr(8'h60, 8'h00);
        repeat (2) @(posedge clk_i);
        #1;
        chk({7'h00, unit_decode_en_o[0]}, 8'h00);
        // outside configuration state nothing changes and reads give zero
        cfg_mode_i = 1'b0;
        wr(8'h30, 8'h00);
        rd(8'h30, d);
        chk(d, 8'h00);
        chk({7'h00, unit_on_o[0]}, 8'h01);
        cfg_mode_i = 1'b1;
        // power control bit linked to activate
        pulse(2);
        chk({7'h00, unit_on_o[0]}, 8'h00);
        rd(8'h30, d);
        chk(d, 8'h00);
        pulse(3);
        rd(8'h30, d);
        chk(d, 8'h01);
        // soft then hard reset restore defaults
        for (int k = 0; k < 2; k++) begin
            wr(IDX_UNIT_SEL, 8'h00);
            wr(8'h30, 8'h01);
            wr(8'h70, 8'h09);
            pulse(k);
            rd(8'h30, d);
            chk(d, 8'h00);
            rd(8'h70, d);
            chk(d, 8'h06);
        end
        // power-on reset in mid-run clears activate and restores defaults
        wr(8'h30, 8'h01);
        resetn_i = 1'b0;
        @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        chk({7'h00, unit_on_o[0]}, 8'h00);
        rd(8'h30, d);
        chk(d, 8'h00);
        rd(8'h74, d);
        chk(d, 8'h02);
        complete_run();
    end
endmodule // test_logical_device_config_bank
